// ### bench/dual_8_16bit_interval_timer_test.sv
/*
  Testbench: register tasks, period, flag, pause and cascade scenarios.
  Assumes the package, design, checker and pad model compiled first.
*/
`timescale 1ns/1ps
module dual_8_16bit_interval_timer_test;
  localparam int INST = 1;
  logic clock = 1'b0;
  logic rstn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic write_strobe;
  logic read_strobe;
  logic [7:0] rdata;
  logic timer_irq_line;
  logic first_square_out;
  logic first_square_oe;
  logic second_square_out;
  logic second_square_oe;
  int irq_count;
  logic first_pin;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_last = 0;
  int gap_cyc;
  int divs[3] = '{interval_timer_pkg::div_2, interval_timer_pkg::div_32,
    interval_timer_pkg::div_128};
  logic [7:0] r;
  logic [7:0] r2;

  always #12.5 clock = ~clock;

  dual_interval_timer #(.ADDR_W(8), .INST_CLOCKS(INST)) dut_u (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .timer_irq_line(timer_irq_line), .first_square_out(first_square_out),
    .first_square_oe(first_square_oe), .second_square_out(second_square_out),
    .second_square_oe(second_square_oe));
  irq_pads pads_u (
    .clock(clock), .rstn(rstn), .timer_irq_line(timer_irq_line),
    .first_square_out(first_square_out), .first_square_oe(first_square_oe),
    .irq_count(irq_count), .first_pin(first_pin));

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_irq();
    while (timer_irq_line !== 1'b1)
    begin
      @(posedge clock);
      #1;
    end
    gap_cyc = cyc - t_last;
    t_last = cyc;
  endtask
  task automatic clr_wait(input logic [7:0] a, input logic [7:0] d, input int exp);
    wr(a, d);
    wait_irq();
    chk_n("period", exp, gap_cyc);
  endtask

  initial
  begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h26 + i[7:0], r);
      chk8("reset read", 8'h00, r);
    end
    rd(8'h30, r);
    chk8("unmapped", 8'h00, r);
    wr(8'h26, 8'h0d);
    repeat (20) @(posedge clock);
    rd(8'h29, r);
    chk8("no clock code", 8'h00, r);
    wr(8'h29, 8'h01);
    foreach (divs[k])
    begin
      wr(8'h26, 8'h40);
      wr(8'h26, {4'h4, k[1:0], 2'h1});
      wait_irq();
      clr_wait(8'h26, {4'h4, k[1:0], 2'h1}, 2 * divs[k] * INST);
    end
    wr(8'h26, 8'h10);
    chk8("pin pulled", 8'h01, {7'h00, first_pin});
    wr(8'h26, 8'h20);
    wr(8'h26, 8'h30);
    chk8("pin high", 8'h01, {7'h00, first_pin});
    wr(8'h26, 8'h10);
    wr(8'h26, 8'h30);
    chk8("pin low", 8'h00, {7'h00, first_pin});
    wr(8'h29, 8'h03);
    wr(8'h26, 8'h71);
    wait_irq();
    chk8("wave", 8'h01, {7'h00, first_square_out});
    wr(8'h26, 8'h71);
    wr(8'h29, 8'h01);
    wait_irq();
    chk_n("old latch", 8 * INST, gap_cyc);
    clr_wait(8'h26, 8'h71, 4 * INST);
    wr(8'h26, 8'h71);
    wr(8'h26, 8'h70);
    rd(8'h26, r);
    chk8("stop on match", 8'h00, r & 8'h80);
    wr(8'h26, 8'h31);
    wr(8'h29, 8'hff);
    wr(8'h26, 8'hb1);
    chk8("masked", 8'h00, {7'h00, timer_irq_line});
    wr(8'h26, 8'hf1);
    chk8("enable", 8'h01, {7'h00, timer_irq_line});
    wr(8'h26, 8'hf3);
    rd(8'h29, r);
    repeat (10) @(posedge clock);
    rd(8'h29, r2);
    chk8("paused", r, r2);
    wr(8'h26, 8'h70);
    rd(8'h29, r);
    repeat (10) @(posedge clock);
    rd(8'h29, r2);
    chk8("stopped", r, r2);
    wr(8'h26, 8'h71);
    rd(8'h29, r);
    chk8("restart", 8'h00, r & 8'hfe);
    wr(8'h26, 8'h30);
    wr(8'h28, 8'h07);
    wr(8'h27, 8'h41);
    wait_irq();
    rd(8'h26, r);
    chk8("first flag", 8'h00, r & 8'h80);
    rd(8'h27, r);
    chk8("second flag", 8'h80, r & 8'h80);
    chk8("second wave", 8'h01, {7'h00, second_square_out});
    chk8("second pin off", 8'h00, {7'h00, second_square_oe});
    wr(8'h28, 8'hff);
    rd(8'h28, r);
    chk8("count read", 8'h00, r & 8'hf8);
    clr_wait(8'h27, 8'h41, 16 * INST);
    wr(8'h27, 8'h00);
    wr(8'h27, 8'h0c);
    wr(8'h28, 8'h01);
    wr(8'h29, 8'h02);
    wr(8'h26, 8'h41);
    wait_irq();
    chk8("second frozen", 8'h00, {7'h00, second_square_out});
    rd(8'h28, r);
    chk8("high clear", 8'h00, r);
    clr_wait(8'h26, 8'h41, 2 * 259 * INST);
    rd(8'h27, r);
    chk8("second idle", 8'h00, r & 8'h80);
    chk8("irq seen", 8'h01, {7'h00, irq_count > 0});
    conclude();
  end
endmodule // dual_8_16bit_interval_timer_test

// ### bench/irq_pads.sv
/*
  Far side model: interrupt controller input and the first output pad.
  Assumes the pad is pulled up while the timer does not drive it.
*/
`timescale 1ns/1ps
module irq_pads (
  input wire logic clock,
  input wire logic rstn,
  input wire logic timer_irq_line,
  input wire logic first_square_out,
  input wire logic first_square_oe,
  output int irq_count,
  output logic first_pin
);
  logic prev;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      prev <= 1'b0;
      irq_count <= 0;
    end
    else
    begin
      prev <= timer_irq_line;
      if (timer_irq_line && !prev)
        irq_count <= irq_count + 1;
    end
  end
  assign first_pin = first_square_oe ? first_square_out : 1'b1;
endmodule // irq_pads

// ### bench/timer_checker_sva.sv
/*
  Port checker for the dual interval timer, bound to its top module.
  Assumes one clock and write-tracked run and cascade bits.
*/
`timescale 1ns/1ps
module timer_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] rdata,
  input wire logic timer_irq_line,
  input wire logic first_square_out,
  input wire logic first_square_oe,
  input wire logic second_square_out,
  input wire logic second_square_oe
);
  logic run1;
  logic run2;
  logic casc;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence ctl1_wr;
    write_strobe && addr == 8'h26;
  endsequence
  sequence ctl2_wr;
    write_strobe && addr == 8'h27;
  endsequence
  // Run and cascade bits as last written
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      run1 <= 1'b0;
      run2 <= 1'b0;
      casc <= 1'b0;
    end
    else if (write_strobe && addr == 8'h26)
      run1 <= wdata[0];
    else if (write_strobe && addr == 8'h27)
    begin
      run2 <= wdata[0];
      casc <= wdata[3:2] == 2'h3;
    end
  end
  idle_rdata_a: assert property (!read_strobe |=> rdata == 8'h00)
    else $error("read data not zero after idle cycle");
  unmapped_read_a: assert property (
    read_strobe && (addr < 8'h26 || addr > 8'h29) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  first_pin_a: assert property (
    ctl1_wr |=> first_square_oe == $past(wdata[5:4] == 2'h3))
    else $error("first pin enable wrong");
  second_pin_a: assert property (
    ctl2_wr |=> second_square_oe == $past(wdata[5:4] == 2'h3))
    else $error("second pin enable wrong");
  irq_fall_a: assert property ($fell(timer_irq_line) |-> $past(write_strobe))
    else $error("interrupt fell without a write");
  irq_rise_a: assert property (
    $rose(timer_irq_line) |-> $past(write_strobe || run1 || run2))
    else $error("interrupt rose while idle");
  first_wave_a: assert property (
    $changed(first_square_out) |-> $past(write_strobe || run1))
    else $error("first wave changed while stopped");
  second_wave_a: assert property (
    $changed(second_square_out) |-> $past(write_strobe || (run2 && !casc)))
    else $error("second wave changed while not its own timer");
endmodule // timer_checker

bind dual_interval_timer timer_checker #(.ADDR_W(ADDR_W)) checker_u (
  .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
  .timer_irq_line(timer_irq_line), .first_square_out(first_square_out),
  .first_square_oe(first_square_oe), .second_square_out(second_square_out),
  .second_square_oe(second_square_oe));

// ### include/interval_timer_pkg.sv
/*
  Constants for the dual 8/16-bit interval timer: register offsets, control
  field positions, reset values and count clock divisors.
  Assumes an 8-bit register port with byte offsets.
*/
package interval_timer_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] first_timer_control_off = 8'h26;
  localparam logic [7:0] second_timer_control_off = 8'h27;
  localparam logic [7:0] upper_compare_data_off = 8'h28;
  localparam logic [7:0] lower_compare_data_off = 8'h29;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int flag_bit = 7;
  localparam int irq_enable_bit = 6;
  localparam int square_sel_hi = 5;
  localparam int square_sel_lo = 4;
  localparam int clock_sel_hi = 3;
  localparam int clock_sel_lo = 2;
  localparam int pause_bit = 1;
  localparam int run_bit = 0;

  // ----------------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] clock_sel_2 = 2'h0;
  localparam logic [1:0] clock_sel_32 = 2'h1;
  localparam logic [1:0] clock_sel_128 = 2'h2;
  localparam logic [1:0] clock_sel_cascade = 2'h3;
  localparam logic [1:0] square_set_low = 2'h1;
  localparam logic [1:0] square_set_high = 2'h2;
  localparam logic [1:0] square_pin_on = 2'h3;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;

  // ----------------------------------------------------------------------
  // Timing: system clock cycles per instruction cycle, count clock divisors
  // ----------------------------------------------------------------------
  localparam int inst_cycle_clocks = 4;
  localparam int div_2 = 2;
  localparam int div_32 = 32;
  localparam int div_128 = 128;

endpackage

// ### rtl/count_prescaler.sv
/*
  Count clock prescaler: instruction-cycle tick and the 2, 32 and 128
  instruction-cycle count clock enables.
  Assumes one system clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps
module count_prescaler #(
  parameter int INST_CLOCKS = interval_timer_pkg::inst_cycle_clocks
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick_2,
  output logic tick_32,
  output logic tick_128
);

  typedef struct packed {
    logic [7:0] clk_count;
    logic [6:0] inst_count;
  } prescale_s;

  prescale_s s;
  prescale_s next_s;
  logic inst_tick;

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    inst_tick = (s.clk_count == 8'(INST_CLOCKS - 1));
    next_s.clk_count = inst_tick ? 8'h00 : s.clk_count + 8'h01;
    if (inst_tick)
    begin
      next_s.inst_count = s.inst_count + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick_2 = inst_tick && (s.inst_count[0] == 1'b1);
  assign tick_32 = inst_tick && (s.inst_count[4:0] == 5'(interval_timer_pkg::div_32 - 1));
  assign tick_128 = inst_tick && (s.inst_count == 7'(interval_timer_pkg::div_128 - 1));

endmodule // count_prescaler

// ### rtl/dual_interval_timer.sv
/*
  Dual 8-bit interval timer that cascades into one 16-bit timer, with
  compare latches, match flags, one shared interrupt and square outputs.
  Assumes an 8-bit register port on the same clock, read data one cycle
  after the read strobe, and pins resolved outside from the enables.
*/
`timescale 1ns/1ps
module dual_interval_timer #(
  parameter int ADDR_W = 8,
  parameter int INST_CLOCKS = interval_timer_pkg::inst_cycle_clocks
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] rdata,
  output logic timer_irq_line,
  output logic first_square_out,
  output logic first_square_oe,
  output logic second_square_out,
  output logic second_square_oe
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] data;
    logic [1:0][7:0] latch;
    logic [1:0][7:0] count;
    logic [7:0] rdata;
  } timer_s;

  timer_s s;
  timer_s next_s;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic tick_2;
  logic tick_32;
  logic tick_128;
  logic mode16;
  logic [1:0] wr_ctrl;
  logic [1:0] wr_data;
  logic [1:0] start_edge;
  logic [1:0] stop_now;
  logic [1:0] running;
  logic [1:0] tick;
  logic [1:0] match;
  logic [15:0] count16;
  logic [15:0] latch16;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_pipe <= 2'h0;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------------
  // Count clocks
  // ----------------------------------------------------------------------
  count_prescaler #(
    .INST_CLOCKS(INST_CLOCKS)
  ) prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .tick_2(tick_2),
    .tick_32(tick_32),
    .tick_128(tick_128)
  );

  // ----------------------------------------------------------------------
  // Decode and control
  // ----------------------------------------------------------------------
  function automatic logic select_tick(input logic [1:0] sel, input logic t2,
                                       input logic t32, input logic t128);
    logic t;
    t = 1'b0;
    case (sel)
      interval_timer_pkg::clock_sel_2: t = t2;
      interval_timer_pkg::clock_sel_32: t = t32;
      interval_timer_pkg::clock_sel_128: t = t128;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  always_comb
  begin
    mode16 = (s.ctrl[1][interval_timer_pkg::clock_sel_hi:interval_timer_pkg::clock_sel_lo]
              == interval_timer_pkg::clock_sel_cascade);
    wr_ctrl[0] = write_strobe && (addr == ADDR_W'(interval_timer_pkg::first_timer_control_off));
    wr_ctrl[1] = write_strobe && (addr == ADDR_W'(interval_timer_pkg::second_timer_control_off));
    wr_data[0] = write_strobe && (addr == ADDR_W'(interval_timer_pkg::lower_compare_data_off));
    wr_data[1] = write_strobe && (addr == ADDR_W'(interval_timer_pkg::upper_compare_data_off));
    for (int i = 0; i < 2; i++)
    begin
      // Run bit rising edge and stop
      start_edge[i] = wr_ctrl[i] && wdata[interval_timer_pkg::run_bit]
                      && !s.ctrl[i][interval_timer_pkg::run_bit];
      stop_now[i] = wr_ctrl[i] && !wdata[interval_timer_pkg::run_bit];
      running[i] = s.ctrl[i][interval_timer_pkg::run_bit]
                   && !s.ctrl[i][interval_timer_pkg::pause_bit]
                   && !stop_now[i] && !start_edge[i];
      tick[i] = select_tick(
        s.ctrl[i][interval_timer_pkg::clock_sel_hi:interval_timer_pkg::clock_sel_lo],
        tick_2, tick_32, tick_128);
    end
    count16 = {s.count[1], s.count[0]};
    // Upper byte high, lower byte low
    latch16 = {s.latch[1], s.latch[0]};
  end

  // ----------------------------------------------------------------------
  // Counters, latches, flags and registers
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    match = 2'b00;
    for (int i = 0; i < 2; i++)
    begin
      // Zero clears flag, one leaves it
      if (wr_ctrl[i])
      begin
        next_s.ctrl[i] = {s.ctrl[i][interval_timer_pkg::flag_bit]
                          & wdata[interval_timer_pkg::flag_bit], wdata[6:0]};
      end
      if (wr_data[i])
      begin
        next_s.data[i] = wdata;
      end
    end
    if (mode16)
    begin
      if (start_edge[0])
      begin
        // Load both latch bytes at start
        next_s.latch = s.data;
        next_s.count = '0;
      end
      else if (running[0] && tick[0])
      begin
        if (count16 == latch16)
        begin
          match[0] = 1'b1;
          next_s.count = '0;
          next_s.latch = s.data;
        end
        else
        begin
          next_s.count = count16 + 16'h0001;
        end
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (start_edge[i])
        begin
          next_s.latch[i] = s.data[i];
          next_s.count[i] = 8'h00;
        end
        else if (running[i] && tick[i])
        begin
          if (s.count[i] == s.latch[i])
          begin
            match[i] = 1'b1;
            next_s.count[i] = 8'h00;
            next_s.latch[i] = s.data[i];
          end
          else
          begin
            next_s.count[i] = s.count[i] + 8'h01;
          end
        end
      end
    end
    // Stop write masks match via running
    for (int i = 0; i < 2; i++)
    begin
      // Match sets flag, wins over clear
      if (match[i])
      begin
        next_s.ctrl[i][interval_timer_pkg::flag_bit] = 1'b1;
      end
    end
    // Read data, one cycle later
    next_s.rdata = 8'h00;
    if (read_strobe)
    begin
      case (addr)
        ADDR_W'(interval_timer_pkg::first_timer_control_off): next_s.rdata = s.ctrl[0];
        ADDR_W'(interval_timer_pkg::second_timer_control_off): next_s.rdata = s.ctrl[1];
        ADDR_W'(interval_timer_pkg::upper_compare_data_off): next_s.rdata = s.count[1];
        ADDR_W'(interval_timer_pkg::lower_compare_data_off): next_s.rdata = s.count[0];
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.ctrl <= {interval_timer_pkg::control_reset, interval_timer_pkg::control_reset};
      s.data <= {interval_timer_pkg::data_reset, interval_timer_pkg::data_reset};
      s.latch <= '0;
      s.count <= '0;
      s.rdata <= 8'h00;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Flag and enable raise the request, the second timer's only outside cascade mode
  // Level form answers enable at once
  assign timer_irq_line =
    (s.ctrl[0][interval_timer_pkg::flag_bit] && s.ctrl[0][interval_timer_pkg::irq_enable_bit])
    || (!mode16 && s.ctrl[1][interval_timer_pkg::flag_bit]
        && s.ctrl[1][interval_timer_pkg::irq_enable_bit]);

  // ----------------------------------------------------------------------
  // Square wave outputs
  // ----------------------------------------------------------------------
  logic [1:0] sq_out;
  logic [1:0] sq_oe;

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_square
      square_wave_out square (
        .clock(clock),
        .rst_n(rst_n),
        .sel_write(wr_ctrl[g]),
        .sel_value(wdata[interval_timer_pkg::square_sel_hi:interval_timer_pkg::square_sel_lo]),
        .stopped(!s.ctrl[g][interval_timer_pkg::run_bit]),
        .match(match[g]),
        .pin_out(sq_out[g]),
        .pin_oe(sq_oe[g])
      );
    end
  endgenerate

  assign first_square_out = sq_out[0];
  assign first_square_oe = sq_oe[0];
  assign second_square_out = sq_out[1];
  assign second_square_oe = sq_oe[1];

endmodule // dual_interval_timer

// ### rtl/square_wave_out.sv
/*
  Square wave output control for one timer: level latch, initial level set,
  inversion on each match and pin enable.
  Assumes control write strobes and match pulses on the same clock.
*/
`timescale 1ns/1ps
module square_wave_out (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sel_write,
  input wire logic [1:0] sel_value,
  input wire logic stopped,
  input wire logic match,
  output logic pin_out,
  output logic pin_oe
);

  typedef struct packed {
    logic level;
    logic [1:0] sel;
  } square_s;

  square_s s;
  square_s next_s;

  // ----------------------------------------------------------------------
  // Level latch
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (sel_write)
    begin
      next_s.sel = sel_value;
      if (stopped && sel_value == interval_timer_pkg::square_set_low)
      begin
        next_s.level = 1'b0;
      end
      else if (stopped && sel_value == interval_timer_pkg::square_set_high)
      begin
        next_s.level = 1'b1;
      end
    end
    if (match)
    begin
      next_s.level = ~s.level;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pin_out = s.level;
  assign pin_oe = (s.sel == interval_timer_pkg::square_pin_on);

endmodule // square_wave_out
